// ===== tmr_cfg.svh
// Address map, field positions, reset values and clock rates of the sensor timer set
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ==========================================
// Clock rates (Hz)
`define SYS_HZ 28'h7735940
`define T2_HZ_FAST 28'h16E3600
`define T2_HZ_MED 28'h01E8480
`define T2_HZ_SLOW 28'h0008000

// ==========================================
// Register offsets
`define OFS_CTRL 8'h00
`define OFS_GP_CFG0 8'h04
`define OFS_GP_STRIDE 8'h0C
`define OFS_T2_TGT 8'h1C
`define OFS_T2_CNT 8'h20
`define OFS_CH_CFG0 8'h24
`define OFS_CH_STRIDE 8'h08
`define OFS_STAT 8'h44
`define OFS_MASK 8'h48
`define OFS_ADC_SEL 8'h4C

// ==========================================
// Control register fields
`define CTRL_T2_EN 0
`define CTRL_T2_SEL_LO 1
`define CTRL_T2_ONESHOT 3
`define CTRL_ARM_LO 8
`define CTRL_STOP_LO 10

// ==========================================
// Timer 0/1 configuration fields
`define GP_PRESC_HI 3
`define GP_TICK_MODE 4
`define GP_ONESHOT 5
`define GP_SRC_LO 6

// ==========================================
// Channel configuration fields
`define CH_CAPTURE 0
`define CH_ONESHOT 1
`define CH_MODE_LO 2
`define CH_ARM 4
`define CH_OUT 5

// ==========================================
// Event bits and reset values
`define EV_GP0 0
`define EV_T2_WRAP 2
`define EV_CH0 3
`define RST_TGT 16'hFFFF
`define RST_ZERO16 16'h0000

`endif

// ===== tmr_pkg.sv
// Types shared by the sensor timer set
package tmr_pkg;

  typedef enum logic [1:0] {
    OUT_TOGGLE,
    OUT_SET,
    OUT_CLEAR,
    OUT_PWM
  } out_mode_t;

  typedef enum logic [1:0] {
    T2_FAST,
    T2_MED,
    T2_SLOW,
    T2_SLOW_ALT
  } t2_clk_t;

  typedef struct packed {
    logic capture;
    logic oneshot;
    out_mode_t mode;
    logic armed;
    logic out;
    logic [15:0] val;
  } chan_t;

  typedef struct packed {
    logic run;
    logic tick_d;
    logic [15:0] pc;
    logic [15:0] cnt;
    logic evt;
  } gp_state_t;

  typedef struct packed {
    logic [3:0] tick_s1;
    logic [3:0] tick_s2;
    logic [3:0] cap_s1;
    logic [3:0] cap_s2;
    logic [3:0] cap_d;
    logic [1:0][7:0] gp_cfg;
    logic [1:0][15:0] gp_tgt;
    logic t2_en;
    t2_clk_t t2_sel;
    logic t2_oneshot;
    logic [27:0] acc;
    logic [15:0] t2_tgt;
    logic [15:0] t2_cnt;
    chan_t [3:0] ch;
    logic [6:0] stat;
    logic [6:0] mask;
    logic [6:0] adc_sel;
    logic [6:0] evt;
    logic adc_trig;
    logic [31:0] rdata;
  } tmr_state_t;

endpackage

// ===== gp_timer.sv
// 16-bit counter with power-of-two prescaler, tick mode and one-shot/periodic modes
`timescale 1ns/1ps
`include "tmr_cfg.svh"

module gp_timer (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic arm_i,
  input wire logic stop_i,
  input wire logic [3:0] presc_i,
  input wire logic tick_mode_i,
  input wire logic oneshot_i,
  input wire logic tick_i,
  input wire logic [15:0] target_i,
  output logic [15:0] cnt_o,
  output logic run_o,
  output logic evt_o
);
  import tmr_pkg::*;

  gp_state_t s_r;
  gp_state_t s_nxt;
  logic [15:0] pmask;
  logic step;

  always_comb begin
    s_nxt = s_r;
    s_nxt.evt = 1'b0;
    s_nxt.tick_d = tick_i;
    pmask = ~(16'hFFFF << presc_i);
    step = 1'b0;
    if (s_r.run) begin
      if (tick_mode_i) begin
        step = tick_i ^ s_r.tick_d;
      end else begin
        step = (s_r.pc == pmask);
        s_nxt.pc = step ? `RST_ZERO16 : s_r.pc + 16'h0001;
      end
    end
    if (step) begin
      if (s_r.cnt == target_i) begin
        s_nxt.evt = 1'b1;
        if (oneshot_i) begin
          s_nxt.run = 1'b0;
        end else begin
          s_nxt.cnt = `RST_ZERO16;
        end
      end else begin
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end
    if (stop_i) begin
      s_nxt.run = 1'b0;
    end
    // Arming restarts from zero so a one-shot can be fired again
    if (arm_i) begin
      s_nxt.run = 1'b1;
      s_nxt.cnt = `RST_ZERO16;
      s_nxt.pc = `RST_ZERO16;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cnt_o = s_r.cnt;
  assign run_o = s_r.run;
  assign evt_o = s_r.evt;
endmodule

// ===== sensor_domain_timer_set.sv
// Sensor-domain timer set: two prescaled timers and a four-channel capture/compare timer
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "tmr_cfg.svh"

// Summary of operation
// - Three independent timers 0, 1 and 2 are run without any help from the main processor.
// - Timers 0 and 1 are 16-bit counters behind a prescaler dividing by a power of two.
// - Timers 0 and 1 advance on each prescaled clock or on each edge of a chosen tick input.
// - Timers 0 and 1 run once and stop in one-shot mode, or repeat runs in periodic mode.
// - Timer 2 is a 16-bit counter clocked at 24 MHz, 2 MHz or 32 kHz, free of the processor.
// - Timer 2 has four channels, each capture or compare, each one-shot or periodic.
// - Timer 2 events are pulsed to the processor and can trigger the ADC.
// - Timer 2 compare channels drive outputs that can form PWM or other waveforms.
module sensor_domain_timer_set (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  input wire logic [3:0] tick_src_i,
  input wire logic [3:0] capture_i,
  output logic [3:0] compare_o,
  output logic [6:0] event_o,
  output logic adc_trig_o,
  output logic irq_o
);
  import tmr_pkg::*;

  tmr_state_t s_r;
  tmr_state_t s_nxt;
  logic [1:0] gp_arm;
  logic [1:0] gp_stop;
  logic [1:0] gp_run;
  logic [1:0] gp_evt;
  logic [1:0][15:0] gp_cnt;
  logic [27:0] t2_rate;
  logic [27:0] acc_sum;
  logic t2_step;
  logic t2_wrap;
  logic [3:0] ch_evt;
  logic [3:0] cap_rise;
  logic [6:0] evt_now;

  // ==========================================
  // Address decode helpers
  function automatic logic hit_gp(input logic [7:0] a, input int unsigned i,
                                  input int unsigned k);
    hit_gp = (a == 8'(`OFS_GP_CFG0 + i * `OFS_GP_STRIDE + k * 4));
  endfunction

  function automatic logic hit_ch(input logic [7:0] a, input int unsigned i,
                                  input int unsigned k);
    hit_ch = (a == 8'(`OFS_CH_CFG0 + i * `OFS_CH_STRIDE + k * 4));
  endfunction

  // ==========================================
  // Timers 0 and 1
  assign gp_arm = (wr_i && addr_i == `OFS_CTRL) ? wr_data_i[`CTRL_ARM_LO+:2] : 2'b00;
  assign gp_stop = (wr_i && addr_i == `OFS_CTRL) ? wr_data_i[`CTRL_STOP_LO+:2] : 2'b00;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_gp
      gp_timer u_gp (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .arm_i(gp_arm[g]),
        .stop_i(gp_stop[g]),
        .presc_i(s_r.gp_cfg[g][`GP_PRESC_HI:0]),
        .tick_mode_i(s_r.gp_cfg[g][`GP_TICK_MODE]),
        .oneshot_i(s_r.gp_cfg[g][`GP_ONESHOT]),
        .tick_i(s_r.tick_s2[s_r.gp_cfg[g][`GP_SRC_LO+:2]]),
        .target_i(s_r.gp_tgt[g]),
        .cnt_o(gp_cnt[g]),
        .run_o(gp_run[g]),
        .evt_o(gp_evt[g])
      );
    end
  endgenerate

  // ==========================================
  // Timer 2 clock enable
  // A fractional accumulator gives the exact average rate; the enable jitters by one
  // system cycle, which is invisible at these rates.
  always_comb begin
    case (s_r.t2_sel)
      T2_FAST: t2_rate = `T2_HZ_FAST;
      T2_MED: t2_rate = `T2_HZ_MED;
      default: t2_rate = `T2_HZ_SLOW;
    endcase
  end

  assign acc_sum = s_r.acc + t2_rate;
  assign t2_step = s_r.t2_en && (acc_sum >= `SYS_HZ);
  assign t2_wrap = t2_step && (s_r.t2_cnt == s_r.t2_tgt);

  // ==========================================
  // Channel events
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cap_rise[i] = s_r.cap_s2[i] && !s_r.cap_d[i];
      if (s_r.ch[i].capture) begin
        ch_evt[i] = s_r.ch[i].armed && cap_rise[i];
      end else begin
        ch_evt[i] = s_r.ch[i].armed && t2_step && (s_r.t2_cnt == s_r.ch[i].val);
      end
    end
  end

  assign evt_now = {ch_evt, t2_wrap, gp_evt};

  // ==========================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick_s1 = tick_src_i;
    s_nxt.tick_s2 = s_r.tick_s1;
    s_nxt.cap_s1 = capture_i;
    s_nxt.cap_s2 = s_r.cap_s1;
    s_nxt.cap_d = s_r.cap_s2;
    s_nxt.evt = evt_now;
    s_nxt.adc_trig = |(evt_now & s_r.adc_sel);
    s_nxt.rdata = 32'h00000000;

    // Timer 2 counting
    if (s_r.t2_en) begin
      s_nxt.acc = t2_step ? acc_sum - `SYS_HZ : acc_sum;
    end
    if (t2_step) begin
      if (t2_wrap) begin
        if (s_r.t2_oneshot) begin
          s_nxt.t2_en = 1'b0;
        end else begin
          s_nxt.t2_cnt = `RST_ZERO16;
        end
      end else begin
        s_nxt.t2_cnt = s_r.t2_cnt + 16'h0001;
      end
    end

    // Channel actions
    for (int i = 0; i < 4; i++) begin
      if (!s_r.ch[i].capture && s_r.ch[i].mode == OUT_PWM && s_r.ch[i].armed && t2_wrap) begin
        s_nxt.ch[i].out = 1'b1;
      end
      if (ch_evt[i]) begin
        if (s_r.ch[i].capture) begin
          s_nxt.ch[i].val = s_r.t2_cnt;
        end else begin
          case (s_r.ch[i].mode)
            OUT_TOGGLE: s_nxt.ch[i].out = !s_r.ch[i].out;
            OUT_SET: s_nxt.ch[i].out = 1'b1;
            OUT_CLEAR: s_nxt.ch[i].out = 1'b0;
            OUT_PWM: s_nxt.ch[i].out = 1'b0;
            default: s_nxt.ch[i].out = s_r.ch[i].out;
          endcase
        end
        if (s_r.ch[i].oneshot) begin
          s_nxt.ch[i].armed = 1'b0;
        end
      end
    end

    // Sticky flags; a new event beats a clear in the same cycle
    if (wr_i && addr_i == `OFS_STAT) begin
      s_nxt.stat = (s_r.stat & ~wr_data_i[6:0]) | evt_now;
    end else begin
      s_nxt.stat = s_r.stat | evt_now;
    end

    // Register writes
    if (wr_i) begin
      case (addr_i)
        `OFS_CTRL: begin
          s_nxt.t2_en = wr_data_i[`CTRL_T2_EN];
          s_nxt.t2_sel = t2_clk_t'(wr_data_i[`CTRL_T2_SEL_LO+:2]);
          s_nxt.t2_oneshot = wr_data_i[`CTRL_T2_ONESHOT];
          if (wr_data_i[`CTRL_T2_EN] && !s_r.t2_en) begin
            s_nxt.acc = 28'h0000000;
          end
        end
        `OFS_T2_TGT: s_nxt.t2_tgt = wr_data_i[15:0];
        `OFS_T2_CNT: s_nxt.t2_cnt = wr_data_i[15:0];
        `OFS_MASK: s_nxt.mask = wr_data_i[6:0];
        `OFS_ADC_SEL: s_nxt.adc_sel = wr_data_i[6:0];
        default: begin
        end
      endcase
      for (int i = 0; i < 2; i++) begin
        if (hit_gp(addr_i, i, 0)) begin
          s_nxt.gp_cfg[i] = wr_data_i[7:0];
        end
        if (hit_gp(addr_i, i, 1)) begin
          s_nxt.gp_tgt[i] = wr_data_i[15:0];
        end
      end
      for (int i = 0; i < 4; i++) begin
        if (hit_ch(addr_i, i, 0)) begin
          s_nxt.ch[i].capture = wr_data_i[`CH_CAPTURE];
          s_nxt.ch[i].oneshot = wr_data_i[`CH_ONESHOT];
          s_nxt.ch[i].mode = out_mode_t'(wr_data_i[`CH_MODE_LO+:2]);
          s_nxt.ch[i].armed = wr_data_i[`CH_ARM];
          s_nxt.ch[i].out = wr_data_i[`CH_OUT];
        end
        if (hit_ch(addr_i, i, 1)) begin
          s_nxt.ch[i].val = wr_data_i[15:0];
        end
      end
    end

    // Register reads, answered one cycle later; unmapped addresses read zero
    if (rd_i) begin
      case (addr_i)
        `OFS_CTRL: begin
          s_nxt.rdata[`CTRL_T2_EN] = s_r.t2_en;
          s_nxt.rdata[`CTRL_T2_SEL_LO+:2] = s_r.t2_sel;
          s_nxt.rdata[`CTRL_T2_ONESHOT] = s_r.t2_oneshot;
          s_nxt.rdata[`CTRL_ARM_LO+:2] = gp_run;
        end
        `OFS_T2_TGT: s_nxt.rdata[15:0] = s_r.t2_tgt;
        `OFS_T2_CNT: s_nxt.rdata[15:0] = s_r.t2_cnt;
        `OFS_STAT: s_nxt.rdata[6:0] = s_r.stat;
        `OFS_MASK: s_nxt.rdata[6:0] = s_r.mask;
        `OFS_ADC_SEL: s_nxt.rdata[6:0] = s_r.adc_sel;
        default: begin
        end
      endcase
      for (int i = 0; i < 2; i++) begin
        if (hit_gp(addr_i, i, 0)) begin
          s_nxt.rdata[7:0] = s_r.gp_cfg[i];
        end
        if (hit_gp(addr_i, i, 1)) begin
          s_nxt.rdata[15:0] = s_r.gp_tgt[i];
        end
        if (hit_gp(addr_i, i, 2)) begin
          s_nxt.rdata[15:0] = gp_cnt[i];
        end
      end
      for (int i = 0; i < 4; i++) begin
        if (hit_ch(addr_i, i, 0)) begin
          s_nxt.rdata[`CH_CAPTURE] = s_r.ch[i].capture;
          s_nxt.rdata[`CH_ONESHOT] = s_r.ch[i].oneshot;
          s_nxt.rdata[`CH_MODE_LO+:2] = s_r.ch[i].mode;
          s_nxt.rdata[`CH_ARM] = s_r.ch[i].armed;
          s_nxt.rdata[`CH_OUT] = s_r.ch[i].out;
        end
        if (hit_ch(addr_i, i, 1)) begin
          s_nxt.rdata[15:0] = s_r.ch[i].val;
        end
      end
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.gp_tgt <= {`RST_TGT, `RST_TGT};
      s_r.t2_tgt <= `RST_TGT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign rd_data_o = s_r.rdata;
  assign event_o = s_r.evt;
  assign adc_trig_o = s_r.adc_trig;
  assign irq_o = |(s_r.stat & s_r.mask);

  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_out
      assign compare_o[g] = s_r.ch[g].out;
    end
  endgenerate
endmodule

// ===== sdt_props.sv
// Port-level assertion checker for the sensor timer set
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module sdt_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [3:0] tick_src_i,
  input wire logic [3:0] capture_i,
  input wire logic [3:0] compare_o,
  input wire logic [6:0] event_o,
  input wire logic adc_trig_o,
  input wire logic irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Bus, events and interrupt
  a_rd_one_cycle: assert property (rd_data_o != 32'h0 |-> $past(rd_i))
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'h50 |=> rd_data_o == 32'h0)
    else $error("unmapped read not zero");
  a_cnt_width: assert property (rd_i && addr_i == 8'h0C |=> rd_data_o[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  a_stat_width: assert property (rd_i && addr_i == `OFS_STAT |=> rd_data_o[31:7] == 25'h0)
    else $error("status upper bits set");
  a_adc_from_evt: assert property (adc_trig_o |-> event_o != 7'h00)
    else $error("adc trigger without event");
  a_reset_quiet: assert property ($fell(rst_i) |-> event_o == 7'h00
    && compare_o == 4'h0 && !irq_o && !adc_trig_o)
    else $error("outputs active after reset");
  a_irq_rise: assert property (!irq_o && !wr_i |=> !irq_o || event_o != 7'h00)
    else $error("interrupt rose without cause");
  a_irq_hold: assert property (irq_o && !wr_i |=> irq_o)
    else $error("interrupt dropped without clear");
  a_mask_off: assert property (wr_i && addr_i == `OFS_MASK
    && wr_data_i[6:0] == 7'h00 |=> !irq_o)
    else $error("interrupt high with mask zero");
  c_gp0_evt: cover property (event_o[0]);
  c_irq_up: cover property ($rose(irq_o));
  c_adc: cover property (adc_trig_o);
endmodule
bind sensor_domain_timer_set sdt_props u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .tick_src_i(tick_src_i), .capture_i(capture_i), .compare_o(compare_o),
  .event_o(event_o), .adc_trig_o(adc_trig_o), .irq_o(irq_o));

// ===== adc_sink.sv
// Far-side model: ADC trigger input and channel 0 event counter
`timescale 1ns/1ps
module adc_sink (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [6:0] event_i,
  input wire logic adc_trig_i,
  output logic [15:0] trig_cnt_o,
  output logic [15:0] ch0_cnt_o
);
  // Counts every cycle seen high, so a stretched pulse shows as extra counts
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_cnt_o <= 16'h0000;
      ch0_cnt_o <= 16'h0000;
    end else begin
      trig_cnt_o <= trig_cnt_o + {15'h0000, adc_trig_i};
      ch0_cnt_o <= ch0_cnt_o + {15'h0000, event_i[3]};
    end
  end
endmodule

// ===== test_sensor_domain_timer_set.sv
// Self-checking bench for the sensor timer set
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module test_sensor_domain_timer_set;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] tick_src_i = 4'h0;
  logic [3:0] capture_i = 4'h0;
  logic [31:0] rd_data_o;
  logic [3:0] compare_o;
  logic [6:0] event_o;
  logic adc_trig_o;
  logic irq_o;
  logic [15:0] trig_cnt;
  logic [15:0] ch0_cnt;
  logic [31:0] d;
  int num_errors = 0;
  int check_count = 0;

  sensor_domain_timer_set uut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .tick_src_i(tick_src_i), .capture_i(capture_i), .compare_o(compare_o),
    .event_o(event_o), .adc_trig_o(adc_trig_o), .irq_o(irq_o));
  adc_sink far (.mclk_i(mclk_i), .rst_i(rst_i), .event_i(event_o), .adc_trig_i(adc_trig_o),
    .trig_cnt_o(trig_cnt), .ch0_cnt_o(ch0_cnt));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  // ==========================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    v = rd_data_o;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    chk(d, e);
  endtask

  // Bounded wait for a pulse on one event bit; t is the cycles spent
  task automatic gap(input int b, output int t);
    t = 0;
    do begin
      @(negedge mclk_i);
      t++;
    end while (event_o[b] !== 1'b1 && t < 300);
  endtask

  task automatic irqc(input logic e);
    @(negedge mclk_i);
    chk(irq_o, e);
  endtask

  // ==========================================
  // Scenarios
  task automatic s_reset;
    rchk(8'h08, 32'hFFFF);
    rchk(`OFS_T2_TGT, 32'hFFFF);
    rchk(`OFS_CTRL, 32'h0);
    rchk(`OFS_STAT, 32'h0);
    rchk(8'h50, 32'h0);
  endtask

  task automatic s_oneshot;
    int n;
    n = 0;
    wr(`OFS_GP_CFG0, 32'h20);
    wr(8'h08, 32'h3);
    wr(`OFS_CTRL, 32'h100);
    repeat (20) begin
      @(negedge mclk_i);
      if (event_o[0] === 1'b1) n++;
    end
    chk(n, 1);
    rchk(8'h0C, 32'h3);
    rchk(`OFS_CTRL, 32'h0);
    rchk(`OFS_STAT, 32'h1);
    wr(`OFS_STAT, 32'h1);
    rchk(`OFS_STAT, 32'h0);
  endtask

  // Divide by 4, target 1: one event every 8 cycles
  task automatic s_periodic;
    int t;
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h1);
    wr(`OFS_CTRL, 32'h200);
    gap(1, t);
    gap(1, t);
    chk(t, 8);
    gap(1, t);
    chk(t, 8);
    rchk(`OFS_CTRL, 32'h200);
    wr(`OFS_CTRL, 32'h800);
    rchk(`OFS_CTRL, 32'h0);
  endtask

  task automatic s_tick;
    wr(`OFS_STAT, 32'h7F);
    wr(`OFS_GP_CFG0, 32'h70);
    wr(8'h08, 32'h3);
    wr(`OFS_CTRL, 32'h100);
    for (int i = 0; i < 4; i++) begin
      rchk(8'h0C, i);
      @(posedge mclk_i);
      tick_src_i[1] <= ~tick_src_i[1];
      cyc(8);
    end
    rchk(`OFS_STAT, 32'h1);
  endtask

  task automatic s_irq;
    wr(`OFS_MASK, 32'h1);
    irqc(1'b1);
    wr(`OFS_MASK, 32'h0);
    irqc(1'b0);
    wr(`OFS_MASK, 32'h1);
    irqc(1'b1);
    wr(`OFS_STAT, 32'h1);
    irqc(1'b0);
  endtask

  task automatic s_t2;
    int n;
    longint e;
    longint hz[3];
    hz = '{`T2_HZ_FAST, `T2_HZ_MED, `T2_HZ_SLOW};
    n = 0;
    wr(`OFS_T2_TGT, 32'h9);
    wr(`OFS_CH_CFG0, 32'h1C);
    wr(8'h28, 32'h4);
    wr(`OFS_ADC_SEL, 32'h8);
    wr(`OFS_CTRL, 32'h1);
    repeat (300) begin
      @(negedge mclk_i);
      if (compare_o[0] === 1'b1) n++;
    end
    chk(trig_cnt, ch0_cnt);
    chk(ch0_cnt inside {16'h5, 16'h6}, 1);
    chk(n > 80 && n < 170, 1);
    wr(`OFS_T2_TGT, 32'hFFFF);
    for (int s = 0; s < 3; s++) begin
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_T2_CNT, 32'h0);
      wr(`OFS_CTRL, 32'h1 | (s << 1));
      cyc(250);
      rd(`OFS_T2_CNT, d);
      e = 250 * hz[s] / `SYS_HZ;
      chk((longint'(d) - e) inside {-1, 0, 1}, 1);
    end
  endtask

  // Timer 2 is on the slow clock here, so the count stands still during capture
  task automatic s_capture;
    wr(8'h2C, 32'h13);
    wr(`OFS_T2_CNT, 32'h1234);
    wr(`OFS_STAT, 32'h7F);
    @(posedge mclk_i);
    capture_i[1] <= 1'b1;
    cyc(8);
    rd(`OFS_STAT, d);
    chk(d[4], 1'b1);
    rchk(8'h30, 32'h1234);
    rd(8'h2C, d);
    chk(d[4:0], 5'h03);
    wr(`OFS_STAT, 32'h7F);
    capture_i[1] <= 1'b0;
    cyc(8);
    capture_i[1] <= 1'b1;
    cyc(8);
    rd(`OFS_STAT, d);
    chk(d[4], 1'b0);
  endtask

  // Timer 2 one-shot run; channels 1..3 compare in clear, set (one-shot) and toggle modes
  task automatic s_modes;
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_T2_TGT, 32'h9);
    wr(`OFS_T2_CNT, 32'h0);
    wr(8'h2C, 32'h38);
    wr(8'h30, 32'h4);
    wr(8'h34, 32'h16);
    wr(8'h38, 32'h4);
    wr(8'h3C, 32'h10);
    wr(8'h40, 32'h4);
    wr(`OFS_STAT, 32'h7F);
    wr(`OFS_CTRL, 32'h9);
    cyc(100);
    rd(`OFS_STAT, d);
    chk(d[6:2], 5'h1F);
    chk(compare_o[3:1], 3'b110);
    rchk(`OFS_T2_CNT, 32'h9);
    rchk(`OFS_CTRL, 32'h8);
    rd(8'h34, d);
    chk(d[4], 1'b0);
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    s_reset();
    s_oneshot();
    s_periodic();
    s_tick();
    s_irq();
    s_t2();
    s_capture();
    s_modes();
    print_verdict();
  end
endmodule
